// ===== adc_seq_pkg.sv
package adc_seq_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets on the bus
	localparam logic [7:0] CONV_CTRL_OFS = 8'h00;
	localparam logic [7:0] ACQ_CLOCK_CTRL_OFS = 8'h04;
	localparam logic [7:0] RESULT_HIGH_OFS = 8'h08;
	localparam logic [7:0] RESULT_LOW_OFS = 8'h0c;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

	// conv_ctrl_reg fields
	localparam int ENABLE_BIT = 0;
	localparam int GO_BIT = 1;
	localparam int CHAN_LSB = 2;
	localparam int CHAN_W = 4;

	// acq_clock_ctrl_reg fields
	localparam int CLK_SEL_LSB = 0;
	localparam int ACQ_SEL_LSB = 3;
	localparam int SEL_W = 3;

	// irq status / mask bit
	localparam int DONE_IRQ_BIT = 0;

	// reset values
	localparam logic [2:0] ACQ_SEL_RESET = 3'h0;
	localparam logic [2:0] CLK_SEL_RESET = 3'h0;

	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RC_PERIOD_NS = 2500;
	localparam int RC_CYCLES = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_PERIODS = 13;
	localparam int HOLDOFF_PERIODS = 2;

	// sequencer states
	typedef enum logic [1:0] {
		ST_SAMPLE = 2'b00,
		ST_ACQ = 2'b01,
		ST_CONV = 2'b10,
		ST_HOLD = 2'b11
	} seq_state_t;

endpackage

// ===== in_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module in_sync3 (
	input wire logic clock,
	input wire logic nrst,
	input wire logic din,
	output logic dout
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// three-stage sync, change accepted when last two agree
	always_ff @(posedge clock) begin
		if (!nrst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				dout <= s3_r;
			end
		end
	end
endmodule // in_sync3
`default_nettype wire

// ===== tad_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tad_tick_gen
	import adc_seq_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic restart,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [7:0] div_r;
	logic [7:0] rc_r;
	logic [7:0] last;

	// RULE9 divider end value per select code
	always_comb begin
		case (sel)
			3'b000: last = 8'd1;
			3'b100: last = 8'd3;
			3'b001: last = 8'd7;
			3'b101: last = 8'd15;
			3'b010: last = 8'd31;
			3'b110: last = 8'd63;
			default: last = 8'(RC_CYCLES - 1);
		endcase
	end

	// oscillator divider
	always_ff @(posedge clock) begin
		if (!nrst || restart || div_r >= last) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	// RULE11 stand-in for the internal rc source, free of the select
	always_ff @(posedge clock) begin
		if (!nrst || restart || rc_r == 8'(RC_CYCLES - 1)) begin
			rc_r <= 8'h00;
		end else begin
			rc_r <= rc_r + 8'h01;
		end
	end

	// RULE17 one pulse per conversion-clock period
	always_comb begin
		if (restart) begin
			tick = 1'b0;
		end else if (sel[1:0] == 2'b11) begin
			tick = (rc_r == 8'(RC_CYCLES - 1));
		end else begin
			tick = (div_r >= last);
		end
	end
endmodule // tad_tick_gen
`default_nettype wire

// ===== adc_acquisition_sequencer.sv
// Function
// RULE1 - acq_time_sel sits in bits 5:3, picks 2 to 20 periods
// RULE2 - programmed acquisition samples selected periods, then converts itself
// RULE3 - code 000 means go stops sampling and converts immediately
// RULE4 - acq_time_sel resets to manual 000
// RULE5 - software waits acquisition time before go in manual mode
// RULE6 - completion clears go, sets irq flag, resumes sampling
// RULE7 - no status separates acquisition from conversion; go stays set
// RULE8 - a conversion lasts exactly 13 conversion-clock periods
// RULE9 - conv_clock_sel picks 2..64 oscillator periods or rc source
// RULE10 - software picks shortest period above 0.8 us
// RULE11 - rc source period is 2.5 us regardless of oscillator
// RULE12 - with rc above 1 MHz software sleeps or uses a divider
// RULE13 - result loads into high/low pair; go is control bit 1
// RULE14 - at least 2 periods pass before next acquisition
// RULE15 - reset disables converter, aborts conversion, resets controls
// RULE16 - nonzero codes map 2..20 periods, counted on conversion clock
// RULE17 - one enable pulse per period drives both counters
`timescale 1ns/1ps
`default_nettype none
module adc_acquisition_sequencer
	import adc_seq_pkg::*;
#(
	parameter int RES_W = 12
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cmp_in,
	output logic sample_r,
	output logic [3:0] chan_r,
	output logic [RES_W-1:0] dac_code_r,
	output logic irq_r
);
	initial begin
		if (RES_W != 12) begin
			$error("adc_acquisition_sequencer: only 12-bit results");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic enable_r;
	logic go_r;
	logic [2:0] acq_time_sel_r;
	logic [2:0] conv_clock_sel_r;
	logic [RES_W-1:0] result_r;
	logic conv_irq_flag_r;
	logic irq_mask_r;
	seq_state_t state_r;
	logic [4:0] cnt_r;
	logic [RES_W-1:0] mask_r;
	logic [4:0] acq_periods;
	logic tick;
	logic cmp_sync;
	logic restart;
	logic done;
	logic [RES_W-1:0] decided;
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_fire;
	logic wr_lane0;
	logic ar_fire;
	logic aw_take;
	logic w_take;
	logic b_busy_nxt;

	////////////////////////////////////////////////////////////////////////
	// submodules
	in_sync3 u_cmp_sync (
		.clock(clock),
		.nrst(nrst),
		.din(cmp_in),
		.dout(cmp_sync)
	);

	// RULE17 period enable pulse
	tad_tick_gen u_tick (
		.clock(clock),
		.nrst(nrst),
		.restart(restart),
		.sel(conv_clock_sel_r),
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////////
	// axi write: address and data taken in either order
	assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_lane0 = wr_fire && wstrb_r[0];
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign b_busy_nxt = wr_fire || (s_axi_bvalid && !s_axi_bready);

	// ready flags registered from next held and busy state
	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			s_axi_awready <= !(aw_take || (aw_held_r && !wr_fire))
				&& !b_busy_nxt;
			s_axi_wready <= !(w_take || (w_held_r && !wr_fire))
				&& !b_busy_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			waddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				waddr_r <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// write response, unmapped address answers slverr
	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (waddr_r[1:0] != 2'b00 || waddr_r > IRQ_MASK_OFS) begin
				s_axi_bresp <= RESP_SLVERR;
			end else begin
				s_axi_bresp <= RESP_OKAY;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers
	// RULE15 reset turns converter off
	always_ff @(posedge clock) begin
		if (!nrst) begin
			enable_r <= 1'b0;
			chan_r <= 4'h0;
		end else if (wr_lane0 && waddr_r == CONV_CTRL_OFS) begin
			enable_r <= wdata_r[ENABLE_BIT];
			chan_r <= wdata_r[CHAN_LSB +: CHAN_W];
		end
	end

	// RULE1 RULE4 RULE9 field layout and reset value
	always_ff @(posedge clock) begin
		if (!nrst) begin
			acq_time_sel_r <= ACQ_SEL_RESET;
			conv_clock_sel_r <= CLK_SEL_RESET;
		end else if (wr_lane0 && waddr_r == ACQ_CLOCK_CTRL_OFS) begin
			acq_time_sel_r <= wdata_r[ACQ_SEL_LSB +: SEL_W];
			conv_clock_sel_r <= wdata_r[CLK_SEL_LSB +: SEL_W];
		end
	end

	// RULE13 go is bit 1; RULE6 completion clears it
	always_ff @(posedge clock) begin
		if (!nrst) begin
			go_r <= 1'b0;
		end else if (done || !enable_r) begin
			go_r <= 1'b0;
		end else if (wr_lane0 && waddr_r == CONV_CTRL_OFS) begin
			go_r <= wdata_r[GO_BIT] && wdata_r[ENABLE_BIT];
		end
	end

	// irq flag: set wins over write-one-to-clear
	always_ff @(posedge clock) begin
		if (!nrst) begin
			conv_irq_flag_r <= 1'b0;
		end else if (done) begin
			conv_irq_flag_r <= 1'b1;
		end else if (wr_lane0 && waddr_r == IRQ_STATUS_OFS
			&& wdata_r[DONE_IRQ_BIT]) begin
			conv_irq_flag_r <= 1'b0;
		end
	end

	// irq mask and level output
	always_ff @(posedge clock) begin
		if (!nrst) begin
			irq_mask_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			if (wr_lane0 && waddr_r == IRQ_MASK_OFS) begin
				irq_mask_r <= wdata_r[DONE_IRQ_BIT];
			end
			irq_r <= (conv_irq_flag_r || done) && irq_mask_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// RULE16 acquisition code to period count
	always_comb begin
		case (acq_time_sel_r)
			3'b001: acq_periods = 5'd2;
			3'b010: acq_periods = 5'd4;
			3'b011: acq_periods = 5'd6;
			3'b100: acq_periods = 5'd8;
			3'b101: acq_periods = 5'd12;
			3'b110: acq_periods = 5'd16;
			3'b111: acq_periods = 5'd20;
			default: acq_periods = 5'd0;
		endcase
	end

	// align the period grid to the start of a conversion request
	assign restart = (state_r == ST_SAMPLE) && go_r;

	// last conversion period ends the conversion
	assign done = (state_r == ST_CONV) && tick
		&& cnt_r == 5'(CONV_PERIODS - 1);

	// trial bit kept when input is at or above the dac level
	assign decided = cmp_sync ? dac_code_r : (dac_code_r & ~mask_r);

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_r <= ST_SAMPLE;
			cnt_r <= 5'd0;
			mask_r <= '0;
			dac_code_r <= '0;
			sample_r <= 1'b0;
		end else if (!enable_r || (!go_r && state_r != ST_HOLD)) begin
			// off or go withdrawn: abort to ST_SAMPLE, sampling again only if still enabled
			state_r <= ST_SAMPLE;
			cnt_r <= 5'd0;
			mask_r <= '0;
			sample_r <= enable_r;
		end else begin
			case (state_r)
				ST_SAMPLE: begin
					cnt_r <= 5'd0;
					if (acq_periods == 5'd0) begin
						// RULE3 manual: stop sampling at once
						state_r <= ST_CONV;
						sample_r <= 1'b0;
						dac_code_r <= '0;
					end else begin
						// RULE2 keep sampling for programmed time
						state_r <= ST_ACQ;
						sample_r <= 1'b1;
					end
				end
				ST_ACQ: begin
					if (tick) begin
						cnt_r <= cnt_r + 5'd1;
						// RULE2 RULE16 acquisition count ends
						if (cnt_r == acq_periods - 5'd1) begin
							state_r <= ST_CONV;
							cnt_r <= 5'd0;
							sample_r <= 1'b0;
							dac_code_r <= '0;
						end
					end
				end
				ST_CONV: begin
					if (tick) begin
						// RULE8 thirteen periods per conversion
						cnt_r <= cnt_r + 5'd1;
						if (cnt_r == 5'd0) begin
							mask_r <= {1'b1, {(RES_W-1){1'b0}}};
							dac_code_r <= {1'b1, {(RES_W-1){1'b0}}};
						end else begin
							mask_r <= mask_r >> 1;
							dac_code_r <= decided | (mask_r >> 1);
						end
						if (done) begin
							// RULE14 hold off before sampling again
							state_r <= ST_HOLD;
							cnt_r <= 5'd0;
							dac_code_r <= decided;
							mask_r <= '0;
						end
					end
				end
				ST_HOLD: begin
					if (tick) begin
						cnt_r <= cnt_r + 5'd1;
						// RULE6 RULE14 resume sampling after holdoff
						if (cnt_r == 5'(HOLDOFF_PERIODS - 1)) begin
							state_r <= ST_SAMPLE;
							cnt_r <= 5'd0;
							sample_r <= 1'b1;
						end
					end
				end
				default: begin
					state_r <= ST_SAMPLE;
				end
			endcase
		end
	end

	// RULE13 result pair loads on completion
	always_ff @(posedge clock) begin
		if (!nrst) begin
			result_r <= '0;
		end else if (done) begin
			result_r <= decided;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi read
	assign ar_fire = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
		end else if (ar_fire) begin
			s_axi_arready <= 1'b0;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
		end
	end

	// RULE7 go reads set through acquisition and conversion alike
	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			if (s_axi_araddr == CONV_CTRL_OFS) begin
				s_axi_rdata[ENABLE_BIT] <= enable_r;
				s_axi_rdata[GO_BIT] <= go_r;
				s_axi_rdata[CHAN_LSB +: CHAN_W] <= chan_r;
			end else if (s_axi_araddr == ACQ_CLOCK_CTRL_OFS) begin
				s_axi_rdata[ACQ_SEL_LSB +: SEL_W] <= acq_time_sel_r;
				s_axi_rdata[CLK_SEL_LSB +: SEL_W] <= conv_clock_sel_r;
			end else if (s_axi_araddr == RESULT_HIGH_OFS) begin
				s_axi_rdata[3:0] <= result_r[RES_W-1:8];
			end else if (s_axi_araddr == RESULT_LOW_OFS) begin
				s_axi_rdata[7:0] <= result_r[7:0];
			end else if (s_axi_araddr == IRQ_STATUS_OFS) begin
				s_axi_rdata[DONE_IRQ_BIT] <= conv_irq_flag_r;
			end else if (s_axi_araddr == IRQ_MASK_OFS) begin
				s_axi_rdata[DONE_IRQ_BIT] <= irq_mask_r;
			end else begin
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // adc_acquisition_sequencer
`default_nettype wire

// ===== adc_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_properties
	import adc_seq_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sample_r,
	input wire logic irq_r
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////
	// sampling switch stays open for 8 clocks after it opens
	sequence conv_low;
		!sample_r [*8];
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_RESET: assert property (disable iff (1'b0) !nrst |=>
		!sample_r && !irq_r && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not cleared by reset");
	AST_CONV_LOW: assert property ($fell(sample_r) |-> conv_low)
		else $error("sampling resumed too early");
	AST_IRQ_RISE: assert property ($rose(irq_r) |-> !$past(sample_r))
		else $error("irq rose outside completion");
	AST_RD_ANS: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	AST_RD_END: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid held after rready");
	AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	AST_WR_END: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid held after bready");
	AST_RD_ERR: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
		|-> s_axi_rdata == 32'h0)
		else $error("error read with data");
endmodule // adc_seq_properties
`default_nettype wire

// ===== tb_adc_acquisition_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_acquisition_sequencer import adc_seq_pkg::*;;
	logic clock = 0, nrst = 0, cmp_in = 0, msk = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rdat;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, irq_r, sample_r;
	logic [1:0] bresp, rresp, resp;
	logic [3:0] chan_r;
	logic [11:0] dac_code_r;
	int failures = 0, cmp_count = 0, seed = 44132, vin = 0, cyc = 0;
	int lowc = 0, t_fall = 0, last_low = 0;
	int acq_n[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	int exp_q[$];
	always #5 clock = ~clock;
	// analog input model and sampling timers
	always @(posedge clock) begin
		cmp_in <= (vin >= int'(dac_code_r));
		cyc <= cyc + 1;
		lowc <= sample_r ? 0 : lowc + 1;
		if (!sample_r && lowc == 0) t_fall <= cyc;
		if (sample_r && lowc != 0) last_low <= lowc;
	end
	adc_acquisition_sequencer adc_acquisition_sequencer_i (
		.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cmp_in(cmp_in), .sample_r(sample_r),
		.chan_r(chan_r), .dac_code_r(dac_code_r), .irq_r(irq_r)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wt(input logic lvl);
		int n;
		for (n = 0; n < 20000 && sample_r !== lvl; n++) @(posedge clock);
		if (n == 20000) begin
			failures++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && bvalid !== 1'b1; n++) begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		resp = bresp;
		bready <= 1'b0;
		@(posedge clock);
		if (n == 50) begin
			failures++;
			tally_and_finish();
		end
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && rvalid !== 1'b1; n++) begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
		end
		rdat = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge clock);
		if (n == 50) begin
			failures++;
			tally_and_finish();
		end
	endtask
	// one conversion checked against the model
	task automatic conv(input logic [2:0] cs, input logic [2:0] aq, input int v);
		int p, n, t0, e;
		logic [3:0] ch;
		p = cs[1:0] == 2'b11 ? RC_CYCLES : 2 << (2 * cs[1:0] + cs[2]);
		n = acq_n[aq] * p;
		ch = 4'($random(seed));
		vin = v;
		exp_q.push_back(v);
		wr(ACQ_CLOCK_CTRL_OFS, {26'h0, aq, cs});
		wr(CONV_CTRL_OFS, {26'h0, ch, 2'b01});
		if (aq == 3'h0) repeat (300) @(posedge clock);
		wr(CONV_CTRL_OFS, {26'h0, ch, 2'b11});
		t0 = cyc;
		if (aq != 3'h0) begin
			rd(CONV_CTRL_OFS);
			chk("go_acq", 32'h1, 32'(rdat[GO_BIT]));
			chk("smp_acq", 32'h1, 32'(sample_r));
		end
		wt(1'b0);
		wt(1'b1);
		@(posedge clock);
		chk("conv", 1, 32'(last_low >= 15 * p - 2 && last_low <= 15 * p + 2));
		chk("acq", 1, 32'(t_fall - t0 >= n - 4 && t_fall - t0 <= n + 4));
		e = exp_q.pop_front();
		chk("dac", 32'(e), 32'(dac_code_r));
		rd(CONV_CTRL_OFS);
		chk("go_end", 32'h0, 32'(rdat[GO_BIT]));
		chk("irq", 32'(msk), 32'(irq_r));
		rd(IRQ_STATUS_OFS);
		chk("flag", 32'h1, rdat);
		rd(RESULT_HIGH_OFS);
		chk("res_hi", 32'(e >> 8), rdat);
		rd(RESULT_LOW_OFS);
		chk("res_lo", 32'(e & 255), rdat);
		chk("chan", 32'(ch), 32'(chan_r));
		wr(IRQ_STATUS_OFS, 32'h1);
		chk("irq_clr", 32'h0, 32'(irq_r));
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		rd(ACQ_CLOCK_CTRL_OFS);
		chk("acq_rst", 32'h0, rdat);
		rd(8'h20);
		chk("ur_resp", 32'(RESP_SLVERR), 32'(resp));
		chk("ur_data", 32'h0, rdat);
		wr(8'h24, 32'h1);
		chk("uw_resp", 32'(RESP_SLVERR), 32'(resp));
		$display("test regs done");
		wr(CONV_CTRL_OFS, 32'h1);
		// every divider manual, then every acquisition code
		// random inputs only on periods of 8 clocks or more
		for (int i = 0; i < 15; i++) begin
			if (i < 8)
				conv(3'(i), 3'h0, 4095);
			else
				conv(3'h1, 3'(i - 7), $random(seed) & 4095);
		end
		$display("test timing done");
		msk = 1'b1;
		wr(IRQ_MASK_OFS, 32'h1);
		// period long enough for the comparator path
		conv(3'h5, 3'h2, $random(seed) & 4095);
		$display("test irq done");
		wr(ACQ_CLOCK_CTRL_OFS, 32'h0b);
		wr(CONV_CTRL_OFS, 32'h3);
		repeat (600) @(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		rd(ACQ_CLOCK_CTRL_OFS);
		chk("acq_rst2", 32'h0, rdat);
		rd(CONV_CTRL_OFS);
		chk("ctl_rst", 32'h0, rdat);
		rd(IRQ_STATUS_OFS);
		chk("no_flag", 32'h0, rdat);
		chk("smp_rst", 32'h0, 32'(sample_r));
		$display("test reset done");
		tally_and_finish();
	end
endmodule // tb_adc_acquisition_sequencer
bind adc_acquisition_sequencer adc_seq_properties adc_seq_properties_i (
	.clock(clock), .nrst(nrst), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .sample_r(sample_r), .irq_r(irq_r)
);
`default_nettype wire
